/* icr_interrupt_control.v */
// Interrupt control register with global and peripheral-group enables,
// three enable/flag pairs, event status/mask and a combined core request.
// Assumes event inputs synchronous to mclk and a single-cycle register port.
`timescale 1ns/1ps
`include "icr_defs.vh"

// How it works
// R01 - Global enable gates every request towards the core
// R02 - Peripheral enable gates peripheral group requests
// R03 - Timer overflow requests only while enabled
// R04 - External pin requests only while enabled
// R05 - Port change requests only while enabled
// R06 - Timer overflow sets sticky flag; software clears
// R07 - External pin edge sets sticky flag; software clears
// R08 - Upper port pin change sets flag
// R09 - Return instruction may re-set global enable
// R10 - Core request from enabled flags or peripherals
module icr_interrupt_control #(
    parameter ADDR_W = `ICR_ADDR_W
) (
    input  wire              mclk,
    input  wire              reset,
    input  wire [ADDR_W-1:0] reg_addr,
    input  wire [7:0]        reg_wdata,
    input  wire              reg_wr,
    input  wire              reg_rd,
    output reg  [7:0]        reg_rdata,
    input  wire              timer_zero_ovf,
    input  wire              ext_irq_pin,
    input  wire [3:0]        port_b_upper_pins,
    input  wire              periph_irq_pending,
    input  wire              irq_taken,
    input  wire              return_from_irq_instr,
    output reg               core_irq_req,
    output reg               irq
);

    // Register map seen from software
    //   Offset 0: control word, one byte
    //     bit 7  global enable, gates every request towards the core
    //     bit 6  peripheral group enable
    //     bit 5  timer overflow enable
    //     bit 4  external pin enable
    //     bit 3  port change enable
    //     bit 2  timer overflow flag
    //     bit 1  external pin flag
    //     bit 0  port change flag
    //   Offset 1: event status, sticky, cleared by a read
    //     bit 0  timer overflow seen
    //     bit 1  external pin rising edge seen
    //     bit 2  upper port pin change seen
    //     bit 3  global enable re-armed by a return while it was low
    //   Offset 2: event mask, same layout as the status
    //   Offset 3: live view, read only
    //     bit 0  request towards the core
    //     bit 1  external pin level
    //     bits 7:4  upper port pin levels
    //   Other offsets read zero and ignore writes
    //
    // Timing, counted in mclk edges
    //   Event sampled at edge E sets its flag at E
    //   A read strobed at E+1 already shows the flag
    //   Request towards the core rises after E+1
    //   Side interrupt output rises after E when unmasked
    //   Core acceptance at edge T drops global enable at T
    //   Request falls one edge later
    //
    // Priorities on the global enable
    //   Return from the handler first
    //   Then the core taking a request
    //   Then a software write
    // Software may lose a clear of global enable to a return;
    // the re-arm status bit misses that case, as global enable was still high.
    //
    // Flags
    //   Hardware set beats a software write in the same cycle,
    //   so no event is ever lost to a racing clear.
    //   Software may also write a flag to one, which is handy
    //   for testing the request path without real events.
    //
    // Limits
    //   External pin edge polarity is fixed to rising.
    //   Port change compares against the previous cycle only,
    //   so a pin that toggles every cycle sets the flag each cycle.
    //   Inputs are taken as already synchronous to mclk.

    // Reset image of the control word; only the global enable field is taken from it
    localparam [7:0] CONTROL_RST = `ICR_CONTROL_RST;

    // Interrupt control fields
    reg        global_irq_enable;
    reg        peripheral_irq_enable;
    reg        timer_zero_ovf_enable;
    reg        ext_pin_irq_enable;
    reg        port_change_irq_enable;
    reg        timer_zero_ovf_flag;
    reg        ext_pin_irq_flag;
    reg        port_change_irq_flag;

    // Event status, mask and edge history
    reg  [3:0] evt_status;
    reg  [3:0] evt_mask;
    reg        ext_pin_prev;
    reg  [3:0] pins_prev;
    reg        pins_valid;

    // Decode and next values
    wire       sel_control;
    wire       sel_status;
    wire       sel_mask;
    wire       sel_live;
    wire       wr_control;
    wire       rd_status;
    wire       ext_edge;
    wire       port_change;
    wire       rearm;
    wire [7:0] control_view;
    wire [3:0] evt_set;
    reg  [3:0] next_evt_status;
    reg  [7:0] next_rdata;
    wire       next_core_irq_req;
    wire       next_irq;

    // Sticky flag update: hardware set beats a software clear in the same cycle
    function flag_next;
        input cur;
        input hw_set;
        input sw_wr;
        input sw_val;
        begin
            if (hw_set) begin
                flag_next = 1'b1;
            end else if (sw_wr) begin
                flag_next = sw_val;
            end else begin
                flag_next = cur;
            end
        end
    endfunction

    // Address decode
    function addr_hit;
        input [ADDR_W-1:0] a;
        input [ADDR_W-1:0] ofs;
        begin
            addr_hit = (a == ofs);
        end
    endfunction

    assign sel_control = addr_hit(reg_addr, `ICR_OFS_CONTROL);
    assign sel_status  = addr_hit(reg_addr, `ICR_OFS_EVT_STATUS);
    assign sel_mask    = addr_hit(reg_addr, `ICR_OFS_EVT_MASK);
    assign sel_live    = addr_hit(reg_addr, `ICR_OFS_LIVE);
    assign wr_control  = reg_wr & sel_control;
    assign rd_status   = reg_rd & sel_status;

    // Rising edge on the external pin; edge polarity choice is not offered
    assign ext_edge = ext_irq_pin & ~ext_pin_prev;

    // Any upper port pin differing from last cycle; first cycle ignored
    assign port_change = pins_valid & (port_b_upper_pins != pins_prev); // R08

    // Return re-arms global enable, even if software just cleared it
    assign rearm = return_from_irq_instr & ~global_irq_enable; // R09

    // Assembled view of the control register
    assign control_view = {global_irq_enable,
                           peripheral_irq_enable,
                           timer_zero_ovf_enable,
                           ext_pin_irq_enable,
                           port_change_irq_enable,
                           timer_zero_ovf_flag,
                           ext_pin_irq_flag,
                           port_change_irq_flag};

    // Edge and pin history
    always @(posedge mclk) begin
        if (reset) begin
            ext_pin_prev <= 1'b0;
            pins_prev    <= `ICR_PINS_RST;
            pins_valid   <= 1'b0;
        end else begin
            ext_pin_prev <= ext_irq_pin;
            pins_prev    <= port_b_upper_pins;
            pins_valid   <= 1'b1;
        end
    end

    // Enable fields; the core clears global enable when it takes a request
    always @(posedge mclk) begin
        if (reset) begin
            global_irq_enable      <= CONTROL_RST[`ICR_BIT_GLOBAL_EN];
            peripheral_irq_enable  <= 1'b0;
            timer_zero_ovf_enable  <= 1'b0;
            ext_pin_irq_enable     <= 1'b0;
            port_change_irq_enable <= 1'b0;
        end else begin
            if (return_from_irq_instr) begin
                global_irq_enable <= 1'b1; // R09
            end else if (irq_taken) begin
                global_irq_enable <= 1'b0;
            end else if (wr_control) begin
                global_irq_enable <= reg_wdata[`ICR_BIT_GLOBAL_EN];
            end
            if (wr_control) begin
                peripheral_irq_enable  <= reg_wdata[`ICR_BIT_PERIPH_EN];
                timer_zero_ovf_enable  <= reg_wdata[`ICR_BIT_T0_EN];
                ext_pin_irq_enable     <= reg_wdata[`ICR_BIT_EXT_EN];
                port_change_irq_enable <= reg_wdata[`ICR_BIT_PORT_EN];
            end
        end
    end

    // Flags set by hardware, written by software
    always @(posedge mclk) begin
        if (reset) begin
            timer_zero_ovf_flag  <= 1'b0;
            ext_pin_irq_flag     <= 1'b0;
            port_change_irq_flag <= 1'b0;
        end else begin
            timer_zero_ovf_flag  <= flag_next(timer_zero_ovf_flag, timer_zero_ovf,
                                              wr_control,
                                              reg_wdata[`ICR_BIT_T0_FLAG]); // R06
            ext_pin_irq_flag     <= flag_next(ext_pin_irq_flag, ext_edge,
                                              wr_control,
                                              reg_wdata[`ICR_BIT_EXT_FLAG]); // R07
            port_change_irq_flag <= flag_next(port_change_irq_flag, port_change,
                                              wr_control,
                                              reg_wdata[`ICR_BIT_PORT_FLAG]); // R08
        end
    end

    // Request path towards the core
    //   Each source needs its flag and its own enable.
    //   The peripheral group needs its enable and a pending input.
    //   All of it is then gated by the global enable.
    // Registered, so the core sees a clean level with one cycle of lag.
    // Trade-off: that lag lets a request stand one cycle after the
    // core has accepted it, which the core must tolerate.
    // The peripheral group is gated globally too, so one clear of the
    // global enable silences every source of core_irq_req, but not the side irq output.
    //
    // Side interrupt output
    //   Status bits collect events regardless of the enables.
    //   The mask selects which of them raise the level output.
    //   A status read clears all bits, except events landing
    //   in that same cycle, which survive.
    //   The output follows next status, so an unmasked event
    //   shows after the edge that samples it.
    //
    // Read port
    //   Data are registered and stand only in the cycle after the
    //   strobe; every other cycle reads zero, so a stale value can
    //   never be mistaken for a fresh read.
    //   Address decode is a single compare per register.
    //
    // Combined request towards the core
    assign next_core_irq_req = global_irq_enable & // R01
                               ((timer_zero_ovf_flag  & timer_zero_ovf_enable) | // R03
                                (ext_pin_irq_flag     & ext_pin_irq_enable) | // R04
                                (port_change_irq_flag & port_change_irq_enable) | // R05
                                (peripheral_irq_enable & periph_irq_pending)); // R02

    // Sticky events for the side interrupt output
    assign evt_set = {rearm, port_change, ext_edge, timer_zero_ovf};

    // Read clears status, but a new event in that cycle survives
    always @* begin
        next_evt_status = evt_status;
        if (rd_status) begin
            next_evt_status = 4'h0;
        end
        next_evt_status = next_evt_status | evt_set;
    end

    assign next_irq = |(next_evt_status & evt_mask);

    // Status and mask registers
    always @(posedge mclk) begin
        if (reset) begin
            evt_status <= `ICR_EVT_STATUS_RST;
            evt_mask   <= `ICR_EVT_MASK_RST;
        end else begin
            evt_status <= next_evt_status;
            if (reg_wr & sel_mask) begin
                evt_mask <= reg_wdata[3:0];
            end
        end
    end

    // Read data mux; unmapped offsets read as zero
    always @* begin
        next_rdata = 8'h00;
        if (sel_control) begin
            next_rdata = control_view;
        end else if (sel_status) begin
            next_rdata = {4'h0, evt_status};
        end else if (sel_mask) begin
            next_rdata = {4'h0, evt_mask};
        end else if (sel_live) begin
            next_rdata = {port_b_upper_pins, 2'b00, ext_irq_pin, core_irq_req};
        end
    end

    // Registered outputs; read data valid only the cycle after the strobe
    always @(posedge mclk) begin
        if (reset) begin
            reg_rdata    <= 8'h00;
            core_irq_req <= 1'b0;
            irq          <= 1'b0;
        end else begin
            reg_rdata    <= reg_rd ? next_rdata : 8'h00;
            core_irq_req <= next_core_irq_req; // R10
            irq          <= next_irq;
        end
    end

endmodule

/* icr_defs.vh */
// Constants for the interrupt control register block: offsets, bit
// positions, reset values.
// Assumes it is included by its bare name from the design file.
`ifndef ICR_DEFS_VH
`define ICR_DEFS_VH

// Register offsets on the plain register port
`define ICR_ADDR_W          4
`define ICR_OFS_CONTROL     4'h0
`define ICR_OFS_EVT_STATUS  4'h1
`define ICR_OFS_EVT_MASK    4'h2
`define ICR_OFS_LIVE        4'h3

// Field positions inside interrupt_control
`define ICR_BIT_GLOBAL_EN   7
`define ICR_BIT_PERIPH_EN   6
`define ICR_BIT_T0_EN       5
`define ICR_BIT_EXT_EN      4
`define ICR_BIT_PORT_EN     3
`define ICR_BIT_T0_FLAG     2
`define ICR_BIT_EXT_FLAG    1
`define ICR_BIT_PORT_FLAG   0

// Field positions inside the event status and mask registers
`define ICR_EVT_T0          0
`define ICR_EVT_EXT         1
`define ICR_EVT_PORT        2
`define ICR_EVT_REARM       3
`define ICR_EVT_W           4

// Field positions inside the live state register
`define ICR_LIVE_CORE_REQ   0
`define ICR_LIVE_EXT_PIN    1
`define ICR_LIVE_PINS_LO    4

// Reset values
`define ICR_CONTROL_RST     8'h00
`define ICR_EVT_STATUS_RST  4'h0
`define ICR_EVT_MASK_RST    4'h0
`define ICR_PINS_RST        4'h0

`endif

/* icr_checker_assertions.sv */
// Port checker for the interrupt control block.
// Assumes one clock, control at offset 0 and status at 1.
`timescale 1ns/1ps
module icr_checker #(
    parameter ADDR_W = 4
) (
    input logic              mclk,
    input logic              reset,
    input logic [ADDR_W-1:0] reg_addr,
    input logic              reg_wr,
    input logic              reg_rd,
    input logic [7:0]        reg_rdata,
    input logic              timer_zero_ovf,
    input logic              ext_irq_pin,
    input logic [3:0]        port_b_upper_pins,
    input logic              periph_irq_pending,
    input logic              irq_taken,
    input logic              return_from_irq_instr,
    input logic              core_irq_req,
    input logic              irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // No event of any kind in this cycle
    sequence quiet;
        !timer_zero_ovf && !return_from_irq_instr && !$rose(ext_irq_pin)
            && !$changed(port_b_upper_pins);
    endsequence
    // Read data stand only in the slot after a read
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("stray read data");
    // Request lags the control value by one cycle, so a read predicts it
    req_calc_a: assert property ($past(reg_rd && reg_addr == 0) |->
        core_irq_req == (reg_rdata[7] & ((|(reg_rdata[5:3] & reg_rdata[2:0]))
        | (reg_rdata[6] & $past(periph_irq_pending))))) else $error("bad request");
    taken_block_a: assert property (irq_taken && !return_from_irq_instr && !reg_wr
        ##1 !return_from_irq_instr && !reg_wr |=> !core_irq_req) else $error("not blocked");
    t0_flag_a: assert property (timer_zero_ovf && !reg_wr ##1 reg_rd && reg_addr == 0
        |=> reg_rdata[2]) else $error("timer flag");
    ext_flag_a: assert property ($rose(ext_irq_pin) && !reg_wr ##1 reg_rd
        && reg_addr == 0 |=> reg_rdata[1]) else $error("pin flag");
    port_flag_a: assert property ($changed(port_b_upper_pins) && !reg_wr ##1 reg_rd
        && reg_addr == 0 |=> reg_rdata[0]) else $error("port flag");
    gie_set_a: assert property (return_from_irq_instr ##1 reg_rd && reg_addr == 0
        |=> reg_rdata[7]) else $error("enable not restored");
    irq_clear_a: assert property ((reg_rd && reg_addr == 1) ##0 quiet ##1 quiet
        |=> !irq) else $error("irq stuck");
    cover property (core_irq_req);
    cover property (irq_taken);
    cover property (irq);
endmodule

/* icr_core_model.sv */
// Behavioural core: takes a pending request, later returns from it.
// Assumes request and service enable are synchronous to mclk.
`timescale 1ns/1ps
module icr_core_model #(
    parameter RET_DLY = 12
) (
    input  wire mclk,
    input  wire reset,
    input  wire core_irq_req,
    input  wire svc_en,
    output reg  irq_taken,
    output reg  return_from_irq_instr
);
    reg       busy;
    reg [4:0] cnt;
    // Slow acknowledge so the bench can watch the pending request
    always @(posedge mclk) begin
        irq_taken <= 1'b0;
        return_from_irq_instr <= 1'b0;
        cnt <= cnt + 5'h01;
        if (reset || !(busy || core_irq_req && svc_en)) begin
            busy <= 1'b0;
            cnt <= 5'h00;
        end else if (busy && cnt == RET_DLY) begin
            return_from_irq_instr <= 1'b1;
            busy <= 1'b0;
        end else if (!busy && cnt == 5'h02) begin
            irq_taken <= 1'b1;
            busy <= 1'b1;
            cnt <= 5'h00;
        end
    end
endmodule

/* test_interrupt_control_register.sv */
// Self-checking bench for the interrupt control block.
// Assumes the design, the checker and the core model.
`timescale 1ns/1ps
module test_interrupt_control_register;
    logic       mclk, reset, reg_wr, reg_rd, timer_zero_ovf, ext_irq_pin;
    logic       periph_irq_pending, svc_en;
    logic [3:0] reg_addr, port_b_upper_pins;
    logic [7:0] reg_wdata, rv, m;
    wire  [7:0] reg_rdata;
    wire        irq_taken, return_from_irq_instr, core_irq_req, irq;
    int         err_count, n_compared, i;

    icr_interrupt_control uut (.*);
    icr_core_model core (.*);

    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task chk(input logic [7:0] g, e);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task chb(input logic g, e);
        chk({7'h00, g}, {7'h00, e});
    endtask
    task tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // Read lands in rv; fire raises one event and reads control at once
    task rd(input logic [3:0] a);
        @(posedge mclk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    // Event stands for one edge only, then control is read at once
    task fire(input int s);
        @(posedge mclk);
        if (s == 0) timer_zero_ovf <= 1'b1;
        else if (s == 1) ext_irq_pin <= 1'b1;
        else port_b_upper_pins <= port_b_upper_pins ^ 4'h9;
        @(posedge mclk);
        timer_zero_ovf <= 1'b0;
        ext_irq_pin <= 1'b0;
        {reg_rd, reg_addr} <= {1'b1, 4'h0};
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    task wait_on(input logic w);
        for (int k = 0; k < 50 && (w ? return_from_irq_instr : irq_taken) !== 1'b1; k++)
            tick(1);
        if ((w ? return_from_irq_instr : irq_taken) !== 1'b1) begin
            err_count++;
            wrap_up();
        end
    endtask
    task wrap_up();
        $display("mismatches %0d compares %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        {reset, reg_wr, reg_rd, timer_zero_ovf, ext_irq_pin} = 5'h10;
        {periph_irq_pending, svc_en, reg_addr, port_b_upper_pins, reg_wdata} = 18'h0;
        {err_count, n_compared} = 0;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        // Reset values, unmapped and read-only places
        for (i = 0; i < 5; i++) begin
            rd(i[3:0]);
            chk(rv, 8'h00);
        end
        wr(4'hF, 8'hFF);
        wr(4'h1, 8'hFF);
        rd(4'hF);
        chk(rv, 8'h00);
        // Each source with its enable off and on
        for (i = 0; i < 6; i++) begin
            m = (i > 2) ? (8'h20 >> (i % 3)) : 8'h00;
            wr(4'h0, 8'h80 | m);
            fire(i % 3);
            chk(rv, 8'h80 | m | (8'h04 >> (i % 3)));
            chb(core_irq_req, i > 2);
        end
        // Global and peripheral gating
        wr(4'h0, 8'h3F);
        tick(2);
        chb(core_irq_req, 1'b0);
        wr(4'h0, 8'hC0);
        periph_irq_pending <= 1'b1;
        tick(2);
        chb(core_irq_req, 1'b1);
        wr(4'h0, 8'h80);
        tick(2);
        chb(core_irq_req, 1'b0);
        wr(4'h0, 8'h40);
        periph_irq_pending <= 1'b0;
        // Masked and unmasked events, cleared by a status read
        rd(4'h1);
        wr(4'h2, 8'h01);
        fire(1);
        tick(1);
        chb(irq, 1'b0);
        fire(0);
        tick(1);
        chb(irq, 1'b1);
        rd(4'h1);
        chk(rv, 8'h03);
        tick(1);
        chb(irq, 1'b0);
        // Core takes the request, handler clears the flag, then returns
        wr(4'h0, 8'hA0);
        svc_en <= 1'b1;
        fire(0);
        wait_on(1'b0);
        svc_en <= 1'b0;
        rd(4'h0);
        chk(rv, 8'h24);
        wr(4'h0, 8'h20);
        wait_on(1'b1);
        rd(4'h0);
        chk(rv, 8'hA0);
        rd(4'h1);
        chk(rv, 8'h09);
        wrap_up();
    end
endmodule

bind icr_interrupt_control icr_checker #(.ADDR_W(ADDR_W)) chk_i (.*);
